// file: shared/amb_pkg.sv
// package for the async byte-port memory host controller
package amb_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  // timing figures in ns (startup in us), counts derived (least times round up)
  localparam int T_CYCLE_NS = 35;
  localparam int T_ADDR_WR_GH_NS = 18;
  localparam int T_ADDR_WR_GL_NS = 20;
  localparam int T_WR_PULSE_NS = 15;
  localparam int T_DATA_SETUP_NS = 10;
  localparam int T_WR_RECOVERY_NS = 12;
  localparam int T_HIGH_HOLD_NS = 2;
  localparam int T_OE_ACCESS_NS = 15;
  localparam int T_ADDR_ACCESS_NS = 35;
  localparam int T_OFF_CE_NS = 15;
  localparam int T_STARTUP_US = 2000;
  localparam int C_CYCLE = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_WR_PULSE_RAW =
    (((T_ADDR_WR_GL_NS > T_WR_PULSE_NS) ? T_ADDR_WR_GL_NS : T_WR_PULSE_NS)
     + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_DATA_SETUP = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_WR_PULSE = (C_WR_PULSE_RAW > C_DATA_SETUP) ? C_WR_PULSE_RAW : C_DATA_SETUP;
  localparam int C_RECOVERY_RAW =
    (((T_WR_RECOVERY_NS > T_HIGH_HOLD_NS) ? T_WR_RECOVERY_NS : T_HIGH_HOLD_NS)
     + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_RECOVERY = (C_RECOVERY_RAW < 1) ? 1 : C_RECOVERY_RAW;
  // read sample point: address/drive access plus three-stage sync of data pins
  localparam int C_RD_ACCESS_RAW =
    (((T_ADDR_ACCESS_NS > T_OE_ACCESS_NS) ? T_ADDR_ACCESS_NS : T_OE_ACCESS_NS)
     + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_RD_ACCESS = C_RD_ACCESS_RAW + 3;
  localparam int C_RD_RELEASE = (T_OFF_CE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_STARTUP = (T_STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 18;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } amb_req_t;

  // pins driven toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              sel_n;
    logic              wr_n;
    logic              oe_n;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } amb_pins_t;
endpackage

// file: hdl/amb_pin_sync.sv
`timescale 1ns/1ns
// three-stage synchroniser for the data pins; output valid once stages 2 and 3 agree
module amb_pin_sync
  import amb_pkg::*;
#(
  parameter int W = 8
)(
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  // pin side
  input  wire logic [W-1:0] pin_i,
  // synchronised value
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] val_ff;
  logic [W-1:0] nxt_val;

  // per bit: take the new level only when the two later stages agree
  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      always_comb
      begin
        nxt_val[b] = (s2_ff[b] == s3_ff[b]) ? s3_ff[b] : val_ff[b];
      end
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      val_ff <= '0;
    end
    else
    begin
      s1_ff  <= pin_i;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      val_ff <= nxt_val;
    end
  end

  assign sync_o = val_ff;
endmodule

// file: hdl/amb_host.sv
`timescale 1ns/1ns
// host controller driving an asynchronous byte-wide non-volatile memory
// Operation
// [RULE1] write strobe stays high through every read cycle
// [RULE2] address is valid no later than chip select falling in reads
// [RULE3] memory gives valid data within 15 ns of output drive
// [RULE4] memory holds old data 3 ns after an address change
// [RULE5] memory drives data no sooner than 3 ns after select falls
// [RULE6] memory floats data 15 ns after select rise, 10 ns after drive rise
// [RULE7] write happens while select and strobe are low, ends at first rise
// [RULE8] drive asserted with or after strobe fall keeps memory outputs floating
// [RULE9] raised strobe or select stays high at least 2 ns
// [RULE10] select falling edges and cycles spaced at least 35 ns
// [RULE11] address valid 18 ns before write end, 20 ns if drive low
// [RULE12] strobe low at least 15 ns, address set at its fall
// [RULE13] select low 15 ns before write end, address set at its fall
// [RULE14] write data valid 10 ns before write end, held to the edge
// [RULE15] memory floats 12 ns after strobe fall, drives 3 ns after rise
// [RULE16] select-timed write keeps memory outputs floating
// [RULE17] address stable at least 12 ns after the write ends
// [RULE18] control pins decode deselect, read and write
// [RULE19] wait 2 ms after power-up with select and strobe high
// [RULE20] power-on reset holds select and strobe high beyond startup
module amb_host
  import amb_pkg::*;
#(
  parameter int STARTUP_CYCLES = C_STARTUP
)(
  // clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      resetn_i,
  // user request
  input  wire logic                      req_valid_i,
  input  amb_pkg::amb_req_t              req_i,
  output logic                           req_ready_o,
  // read answer
  output logic                           rsp_valid_o,
  output logic [amb_pkg::DATA_W-1:0]     rsp_data_o,
  // memory pins
  output amb_pkg::amb_pins_t             pins_o,
  input  wire logic [amb_pkg::DATA_W-1:0] dq_i
);
  import amb_pkg::*;

  typedef enum logic [5:0] {
    ST_STARTUP = 6'b000001,
    ST_IDLE    = 6'b000010,
    ST_READ    = 6'b000100,
    ST_RD_END  = 6'b001000,
    ST_WRITE   = 6'b010000,
    ST_RECOVER = 6'b100000
  } amb_state_t;

  amb_state_t        state_ff,  nxt_state;
  logic [CNT_W-1:0]  cnt_ff,    nxt_cnt;
  amb_pins_t         pins_ff,   nxt_pins;
  logic              ready_ff,  nxt_ready;
  logic              rvalid_ff, nxt_rvalid;
  logic [DATA_W-1:0] rdata_ff,  nxt_rdata;
  logic [DATA_W-1:0] dq_sync;

  amb_pin_sync #(
    .W (DATA_W)
  ) u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .pin_i    (dq_i),
    .sync_o   (dq_sync)
  );

  always_comb
  begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_pins   = pins_ff;
    nxt_ready  = 1'b0;
    nxt_rvalid = 1'b0;
    nxt_rdata  = rdata_ff;
    unique case (state_ff)
      ST_STARTUP:
      begin
        // select and strobe stay high until the memory has settled
        nxt_pins.sel_n = 1'b1; // [RULE19]
        nxt_pins.wr_n  = 1'b1; // [RULE20]
        if (cnt_ff >= CNT_W'(STARTUP_CYCLES - 1))
        begin
          nxt_state = ST_IDLE;
          nxt_cnt   = '0;
          nxt_ready = 1'b1;
        end
        else
        begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      ST_IDLE:
      begin
        nxt_ready = 1'b1;
        if (req_valid_i && ready_ff)
        begin
          nxt_ready      = 1'b0;
          nxt_cnt        = '0;
          // address and select/strobe change on the same edge: zero setup allowed
          nxt_pins.addr  = req_i.addr; // [RULE2]
          nxt_pins.sel_n = 1'b0;
          if (req_i.write)
          begin
            // output drive held high through writes so memory never contends
            nxt_pins.wr_n   = 1'b0; // [RULE12]
            nxt_pins.oe_n   = 1'b1; // [RULE8]
            nxt_pins.dq_out = req_i.wdata; // [RULE14]
            nxt_pins.dq_oe  = 1'b1;
            nxt_state       = ST_WRITE;
          end
          else
          begin
            nxt_pins.wr_n  = 1'b1; // [RULE1]
            nxt_pins.oe_n  = 1'b0; // [RULE18]
            nxt_pins.dq_oe = 1'b0;
            nxt_state      = ST_READ;
          end
        end
      end
      ST_READ:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        // sample at access time plus three cycles; synchroniser latency is four cycles
        if (cnt_ff >= CNT_W'(C_RD_ACCESS - 1)) // [RULE3]
        begin
          nxt_rdata      = dq_sync;
          nxt_rvalid     = 1'b1;
          nxt_pins.sel_n = 1'b1;
          nxt_pins.oe_n  = 1'b1;
          nxt_cnt        = '0;
          nxt_state      = ST_RD_END;
        end
      end
      ST_RD_END:
      begin
        // bus stays undriven until the memory has released it
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff >= CNT_W'(C_RD_RELEASE - 1)) // [RULE6]
        begin
          nxt_state = ST_IDLE;
          nxt_ready = 1'b1;
        end
      end
      ST_WRITE:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        // pulse covers 20 ns address-to-end, 15 ns width and 10 ns data setup
        if (cnt_ff >= CNT_W'(C_WR_PULSE - 1)) // [RULE11]
        begin
          // strobe and select rise together; data held through that edge
          nxt_pins.wr_n  = 1'b1; // [RULE7]
          nxt_pins.sel_n = 1'b1; // [RULE13]
          nxt_cnt        = '0;
          nxt_state      = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        nxt_cnt        = cnt_ff + 1'b1;
        nxt_pins.dq_oe = 1'b0;
        // address held 12 ns after the end; also pads the cycle to 35 ns
        if ((cnt_ff >= CNT_W'(C_RECOVERY - 1)) && // [RULE17]
            (CNT_W'(C_WR_PULSE) + cnt_ff + 1'b1 >= CNT_W'(C_CYCLE - 1))) // [RULE10]
        begin
          nxt_state = ST_IDLE; // [RULE9]
          nxt_ready = 1'b1;
        end
      end
      default:
      begin
        nxt_state = ST_STARTUP;
        nxt_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      state_ff         <= ST_STARTUP;
      cnt_ff           <= '0;
      pins_ff.addr     <= '0;
      pins_ff.sel_n    <= 1'b1;
      pins_ff.wr_n     <= 1'b1;
      pins_ff.oe_n     <= 1'b1;
      pins_ff.dq_out   <= DATA_RST;
      pins_ff.dq_oe    <= 1'b0;
      ready_ff         <= 1'b0;
      rvalid_ff        <= 1'b0;
      rdata_ff         <= DATA_RST;
    end
    else
    begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      pins_ff   <= nxt_pins;
      ready_ff  <= nxt_ready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign req_ready_o = ready_ff;
  assign rsp_valid_o = rvalid_ff;
  assign rsp_data_o  = rdata_ff;
  assign pins_o      = pins_ff;
endmodule

// file: sim/amb_host_props.sv
// concurrent checks on the host controller's pins and handshake
`timescale 1ns/1ns
module amb_host_props
  import amb_pkg::*;
#(
  parameter int STARTUP_CYCLES = C_STARTUP
)(
  // watched ports
  input  wire logic                       clock_i,
  input  wire logic                       resetn_i,
  input  wire logic                       req_valid_i,
  input  amb_pkg::amb_req_t               req_i,
  input  wire logic                       req_ready_o,
  input  wire logic                       rsp_valid_o,
  input  wire logic [amb_pkg::DATA_W-1:0] rsp_data_o,
  input  amb_pkg::amb_pins_t              pins_o,
  input  wire logic [amb_pkg::DATA_W-1:0] dq_i
);
  logic [CNT_W-1:0] up_ff;
  logic [CNT_W-1:0] nxt_up;
  // saturates so a long run never wraps back into the startup window
  always_comb nxt_up = (up_ff == '1) ? up_ff : up_ff + 1'b1;
  always_ff @(posedge clock_i) up_ff <= resetn_i ? nxt_up : '0;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  chk_startup_quiet: assert property (up_ff < STARTUP_CYCLES |->
    pins_o.sel_n && pins_o.wr_n && !req_ready_o) else $error("access in startup");
  chk_read_strobe_high: assert property (!pins_o.oe_n |-> pins_o.wr_n)
    else $error("strobe low in read");
  chk_write_no_drive: assert property (!pins_o.wr_n |->
    pins_o.oe_n && pins_o.dq_oe && !pins_o.sel_n) else $error("bad write pins");
  chk_addr_held: assert property (!pins_o.sel_n && !$past(pins_o.sel_n) |->
    $stable(pins_o.addr)) else $error("address moved");
  chk_select_spacing: assert property ($fell(pins_o.sel_n) |=>
    !$fell(pins_o.sel_n) [*3]) else $error("select too soon");
  chk_pulse_width: assert property ($fell(pins_o.wr_n) |->
    !pins_o.wr_n [*2]) else $error("strobe too short");
  chk_data_to_end: assert property ($rose(pins_o.wr_n) |->
    pins_o.dq_oe && $stable(pins_o.dq_out)) else $error("data not held");
  chk_addr_after_end: assert property ($rose(pins_o.wr_n) |->
    $stable(pins_o.addr) [*2]) else $error("address not held");
  chk_read_answer: assert property (req_valid_i && req_ready_o && !req_i.write |->
    ##8 rsp_valid_o) else $error("read answer late");
endmodule

// file: sim/amb_mem_model.sv
// behavioural byte-wide memory answering the host controller's pins
`timescale 1ns/1ns
module amb_mem_model
  import amb_pkg::*;
#(
  parameter int RD_NS = 12
)(
  // pins from the host and the resolved data wire
  input  amb_pkg::amb_pins_t              pins_i,
  input  wire logic [amb_pkg::DATA_W-1:0] bus_i,
  // level the memory puts on the wire
  output logic      [amb_pkg::DATA_W-1:0] dq_o
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  wire wr_act = !pins_i.sel_n && !pins_i.wr_n;
  wire rd_act = !pins_i.sel_n && !pins_i.oe_n && pins_i.wr_n;
  initial dq_o = 8'h5a;
  // the store lands at whichever of select or strobe rises first
  always @(negedge wr_act) mem[pins_i.addr] = bus_i;
  // released lines show the inverse level so a stale byte cannot pass as data
  always @(rd_act or pins_i.addr)
    dq_o <= #(rd_act ? RD_NS : 10) (rd_act ? mem[pins_i.addr] : ~dq_o);
endmodule

// file: sim/amb_host_tb.sv
// self-checking bench for the byte-port memory host controller
`timescale 1ns/1ns
module amb_host_tb;
  import amb_pkg::*;
  logic              clock_i, resetn_i, req_valid_i, req_ready_o, rsp_valid_o;
  amb_req_t          req_i;
  amb_pins_t         pins_o;
  logic [DATA_W-1:0] rsp_data_o, mem_dq, dq_i;
  int                miscompares, samples_checked, cycles;
  logic [14:0]       adr [4] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h0100};
  logic [7:0]        dat [4] = '{8'hff, 8'h00, 8'ha5, 8'h3c};
  // host drive wins the shared wire, else the memory's level
  assign dq_i = pins_o.dq_oe ? pins_o.dq_out : mem_dq;
  amb_host #(.STARTUP_CYCLES(5)) DUT (.clock_i(clock_i), .resetn_i(resetn_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .pins_o(pins_o), .dq_i(dq_i));
  amb_mem_model MEM (.pins_i(pins_o), .bus_i(dq_i), .dq_o(mem_dq));
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // holds the request until the taking edge, then judges the first pin cycle
  task automatic issue(input logic wr, input logic [14:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_i <= '{wr, a, d};
    do @(negedge clock_i); while (req_ready_o !== 1'b1);
    @(posedge clock_i);
    req_valid_i <= 1'b0;
    @(negedge clock_i);
    check({pins_o.addr, pins_o.sel_n}, {a, 1'b0});
    check({pins_o.wr_n, pins_o.oe_n, pins_o.dq_oe}, wr ? 16'h3 : 16'h4);
    if (wr) check(pins_o.dq_out, d);
  endtask
  task automatic rd_byte(input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 1;
    issue(1'b0, a, 8'h00);
    while (rsp_valid_o !== 1'b1)
    begin
      @(negedge clock_i);
      n++;
    end
    check(16'(n), 16'(1 + C_RD_ACCESS));
    check(rsp_data_o, d);
  endtask
  // a write held from reset on must wait out the whole startup time
  task automatic t_startup();
    int n;
    n = 0;
    while (req_ready_o !== 1'b1)
    begin
      @(negedge clock_i);
      check({pins_o.sel_n, pins_o.wr_n}, 16'h3);
      n++;
    end
    check(16'(n >= 5), 16'h1);
    @(posedge clock_i);
    req_valid_i <= 1'b0;
  endtask
  // back-to-back writes at the address extremes, then every byte read back
  task automatic t_edges();
    for (int i = 0; i < 3; i++) issue(1'b1, adr[i], dat[i]);
    for (int i = 0; i < 4; i++) rd_byte(adr[i], dat[i]);
  endtask
  // overwrite, read back, overwrite again and read on one address with no idle gap
  task automatic t_overwrite();
    issue(1'b1, 15'h2aaa, 8'h5a);
    rd_byte(15'h2aaa, 8'h5a);
    issue(1'b1, 15'h2aaa, 8'hc3);
    rd_byte(15'h2aaa, 8'hc3);
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      miscompares++;
      final_report();
    end
  end
  initial
  begin
    miscompares = 0;
    samples_checked = 0;
    cycles = 0;
    resetn_i = 1'b0;
    req_valid_i = 1'b1;
    req_i = '{1'b1, 15'h0100, 8'h3c};
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_startup();
    t_edges();
    t_overwrite();
    final_report();
  end
endmodule
bind amb_host amb_host_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) PROPS (.clock_i(clock_i),
  .resetn_i(resetn_i), .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
  .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .pins_o(pins_o), .dq_i(dq_i));
